/* swpc_config_regs.v */
/*
 * capability register group of one switch port: power data byte,
 * message interrupt capability, vendor header, test words and the
 * link timer overrides.
 * assumes configuration and load ports are synchronous to clk_sys
 * and that a request lasts one cycle.
 */
`timescale 1ns/10ps
`include "swpc_map.vh"

module swpc_config_regs #(
    parameter ADDR_W = 8
) (
    input wire clk_sys,
    input wire reset_n,
    // host configuration port
    input wire cfgWrEn,
    input wire cfgRdEn,
    input wire [ADDR_W-1:0] cfgAddr,
    input wire [3:0] cfgByteEn,
    input wire [31:0] cfgWrData,
    output reg [31:0] cfgRdData,
    output reg cfgRdValid,
    // default load port (SMBus slave or EEPROM autoload)
    input wire loadWrEn,
    input wire [ADDR_W-1:0] loadAddr,
    input wire [3:0] loadByteEn,
    input wire [31:0] loadWrData,
    // built-in link timer values
    input wire [11:0] builtinReplay,
    input wire [13:0] builtinAck,
    // controls toward the port logic
    output reg msgIntEnable,
    output reg legacyIntPermit,
    output reg [2:0] msgMultiEnable,
    output reg [63:0] msgAddress,
    output reg [15:0] msgPayload,
    output reg [11:0] replayTimeout,
    output reg [13:0] ackLatency,
    output reg pmCapDisable,
    output reg msgCapDisable,
    output reg vgaDecodeEnable,
    output reg [31:0] testWord0,
    output reg [31:0] testWord1
);

// ----------------------------------------------------------------
// byte lane expansion
// ----------------------------------------------------------------
wire [31:0] cfgLane; // host byte enables, bit wide
wire [31:0] loadLane; // load byte enables, bit wide

genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
        // one byte enable covers eight data bits
        assign cfgLane[gi*8+7:gi*8] = {8{cfgByteEn[gi]}};
        assign loadLane[gi*8+7:gi*8] = {8{loadByteEn[gi]}};
    end
endgenerate

// ----------------------------------------------------------------
// merge helper
// ----------------------------------------------------------------
// replaces only the bits selected by the mask
function [31:0] merge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [31:0] mask;
    begin
        merge = (oldVal & ~mask) | (newVal & mask);
    end
endfunction

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
wire [7:0] cfgOff; // host offset, byte address
wire [7:0] loadOff; // load offset, byte address

assign cfgOff = cfgAddr[7:0];
assign loadOff = loadAddr[7:0];

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
reg [31:0] pmData; // data byte in 31:24
reg [31:0] msgCtl; // enable and multi-enable bits
reg [31:0] addrLo; // low address, bits 1:0 stay zero
reg [31:0] addrHi; // upper address
reg [31:0] payload; // message data in 15:0
reg [31:0] test0; // test-only word 0
reg [31:0] test1; // test-only word 1
reg [31:0] timers; // replay and ack override word

// next values
reg [31:0] next_pmData;
reg [31:0] next_msgCtl;
reg [31:0] next_addrLo;
reg [31:0] next_addrHi;
reg [31:0] next_payload;
reg [31:0] next_test0;
reg [31:0] next_test1;
reg [31:0] next_timers;

// ----------------------------------------------------------------
// write path
// ----------------------------------------------------------------
// host write first, a load in the same cycle overrides it
always @* begin
    next_pmData = pmData;
    next_msgCtl = msgCtl;
    next_addrLo = addrLo;
    next_addrHi = addrHi;
    next_payload = payload;
    next_test0 = test0;
    next_test1 = test1;
    next_timers = timers;
    // host writes honour writable masks only
    if (cfgWrEn) begin
        case (cfgOff)
            `SWPC_OFF_MSG_CTL: begin
                // enable bits; capable fields stay fixed
                next_msgCtl = merge(msgCtl, cfgWrData, cfgLane & `SWPC_WM_MSG_CTL);
            end
            `SWPC_OFF_ADDR_LO: begin
                // dword aligned, low two bits dropped
                next_addrLo = merge(addrLo, cfgWrData, cfgLane & `SWPC_WM_ADDR_LO);
            end
            `SWPC_OFF_ADDR_HI: begin
                next_addrHi = merge(addrHi, cfgWrData, cfgLane & `SWPC_WM_FULL);
            end
            `SWPC_OFF_PAYLOAD: begin
                next_payload = merge(payload, cfgWrData, cfgLane & `SWPC_WM_PAYLOAD);
            end
            `SWPC_OFF_TEST0: begin
                next_test0 = merge(test0, cfgWrData, cfgLane & `SWPC_WM_FULL);
            end
            `SWPC_OFF_TEST1: begin
                next_test1 = merge(test1, cfgWrData, cfgLane & `SWPC_WM_FULL);
            end
            `SWPC_OFF_TIMERS: begin
                // user values and override enables
                next_timers = merge(timers, cfgWrData, cfgLane & `SWPC_WM_TIMERS);
            end
            default: begin
                // read-only or unmapped: write ignored
                next_pmData = pmData;
            end
        endcase
    end
    // load port may also replace read-only loadable defaults
    if (loadWrEn) begin
        case (loadOff)
            `SWPC_OFF_PM_DATA: begin
                next_pmData = merge(pmData, loadWrData, loadLane & `SWPC_LM_PM_DATA);
            end
            `SWPC_OFF_MSG_CTL: begin
                next_msgCtl = merge(msgCtl, loadWrData, loadLane & `SWPC_WM_MSG_CTL);
            end
            `SWPC_OFF_ADDR_LO: begin
                next_addrLo = merge(addrLo, loadWrData, loadLane & `SWPC_WM_ADDR_LO);
            end
            `SWPC_OFF_ADDR_HI: begin
                next_addrHi = merge(addrHi, loadWrData, loadLane & `SWPC_WM_FULL);
            end
            `SWPC_OFF_PAYLOAD: begin
                next_payload = merge(payload, loadWrData, loadLane & `SWPC_WM_PAYLOAD);
            end
            `SWPC_OFF_TEST0: begin
                next_test0 = merge(test0, loadWrData, loadLane & `SWPC_WM_FULL);
            end
            `SWPC_OFF_TEST1: begin
                next_test1 = merge(test1, loadWrData, loadLane & `SWPC_WM_FULL);
            end
            `SWPC_OFF_TIMERS: begin
                // overrides and capability disables
                next_timers = merge(timers, loadWrData, loadLane & `SWPC_LM_TIMERS);
            end
            default: begin
                // nothing loadable here
                next_pmData = next_pmData;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// register update
// ----------------------------------------------------------------
// every stored field resets to its documented default
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        pmData <= `SWPC_RST_ZERO;
        msgCtl <= `SWPC_RST_ZERO;
        addrLo <= `SWPC_RST_ZERO;
        addrHi <= `SWPC_RST_ZERO;
        payload <= `SWPC_RST_ZERO;
        test0 <= `SWPC_RST_TEST0;
        test1 <= `SWPC_RST_TEST1;
        timers <= `SWPC_RST_ZERO;
    end else begin
        pmData <= next_pmData;
        msgCtl <= next_msgCtl;
        addrLo <= next_addrLo;
        addrHi <= next_addrHi;
        payload <= next_payload;
        test0 <= next_test0;
        test1 <= next_test1;
        timers <= next_timers;
    end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
reg [31:0] next_rdData; // word chosen by host offset

// constant fields are ored onto stored bits
always @* begin
    case (cfgOff)
        `SWPC_OFF_PM_DATA: begin
            // bits 23:22 hardwired zero
            next_rdData = pmData;
        end
        `SWPC_OFF_MSG_CTL: begin
            // id, pointer, capable fields
            next_rdData = msgCtl | `SWPC_RO_MSG_CTL;
        end
        `SWPC_OFF_ADDR_LO: begin
            next_rdData = addrLo;
        end
        `SWPC_OFF_ADDR_HI: begin
            next_rdData = addrHi;
        end
        `SWPC_OFF_PAYLOAD: begin
            next_rdData = payload;
        end
        `SWPC_OFF_VENDOR: begin
            // id, pointer and length
            next_rdData = `SWPC_RO_VENDOR;
        end
        `SWPC_OFF_TEST0: begin
            next_rdData = test0;
        end
        `SWPC_OFF_TEST1: begin
            next_rdData = test1;
        end
        `SWPC_OFF_TIMERS: begin
            // graphics decode bit always one
            next_rdData = timers | `SWPC_RO_TIMERS;
        end
        default: begin
            // unmapped offsets read zero
            next_rdData = `SWPC_RST_ZERO;
        end
    endcase
end

// read answer one cycle after the request
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        cfgRdData <= `SWPC_RST_ZERO;
        cfgRdValid <= 1'b0;
    end else begin
        cfgRdValid <= cfgRdEn;
        if (cfgRdEn) begin
            cfgRdData <= next_rdData;
        end
    end
end

// ----------------------------------------------------------------
// controls toward the port
// ----------------------------------------------------------------
// registered copies of stored fields, plus timer selection
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        msgIntEnable <= 1'b0;
        legacyIntPermit <= 1'b1;
        msgMultiEnable <= 3'h0;
        msgAddress <= 64'h0000000000000000;
        msgPayload <= 16'h0000;
        replayTimeout <= 12'h000;
        ackLatency <= 14'h0000;
        pmCapDisable <= 1'b0;
        msgCapDisable <= 1'b0;
        vgaDecodeEnable <= 1'b1;
        testWord0 <= `SWPC_RST_TEST0;
        testWord1 <= `SWPC_RST_TEST1;
    end else begin
        // message enable excludes legacy signalling
        msgIntEnable <= msgCtl[`SWPC_BIT_MSG_EN];
        legacyIntPermit <= ~msgCtl[`SWPC_BIT_MSG_EN];
        msgMultiEnable <= msgCtl[`SWPC_MME_HI:`SWPC_MME_LO];
        // full 64-bit target, upper half always in use
        msgAddress <= {addrHi, addrLo[31:2], 2'b00};
        msgPayload <= payload[15:0];
        // user replay value wins when overridden
        if (timers[`SWPC_BIT_REPLAY_EN]) begin
            replayTimeout <= timers[11:0];
        end else begin
            replayTimeout <= builtinReplay;
        end
        // user ack latency wins when overridden
        if (timers[`SWPC_BIT_ACK_EN]) begin
            ackLatency <= timers[`SWPC_ACK_HI:`SWPC_ACK_LO];
        end else begin
            ackLatency <= builtinAck;
        end
        pmCapDisable <= timers[`SWPC_BIT_PM_DIS];
        msgCapDisable <= timers[`SWPC_BIT_MSG_DIS];
        vgaDecodeEnable <= 1'b1;
        testWord0 <= test0;
        testWord1 <= test1;
    end
end

endmodule // swpc_config_regs

/* swpc_config_regs_assertions.sv */
/*
 * checker for the switch port capability register group: read timing,
 * constant read fields, reserved bits and interrupt mode outputs.
 * assumes it is bound to swpc_config_regs and sees only its ports.
 */
`timescale 1ns/10ps

module swpc_cfg_checker #(
    parameter ADDR_W = 8
) (
    input wire clk_sys,
    input wire reset_n,
    input wire cfgWrEn,
    input wire cfgRdEn,
    input wire [ADDR_W-1:0] cfgAddr,
    input wire [31:0] cfgRdData,
    input wire cfgRdValid,
    input wire loadWrEn,
    input wire msgIntEnable,
    input wire legacyIntPermit,
    input wire [63:0] msgAddress
);
    // ----------------------------------------------------------------
    // one clock domain, reset disables everything
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // a host read of one offset
    sequence s_rd(logic [7:0] a);
        cfgRdEn && cfgAddr == a;
    endsequence
    // a lone read strobe
    sequence s_lone_rd;
        cfgRdEn ##1 !cfgRdEn;
    endsequence

    property p_rd_pulse;
        s_lone_rd |-> cfgRdValid ##1 !cfgRdValid;
    endproperty
    property p_no_stray;
        cfgRdValid |-> $past(cfgRdEn);
    endproperty
    property p_ctl;
        s_rd(8'h4c) |=> cfgRdData[15:0] == 16'h6405 && cfgRdData[19:17] == 3'b010
            && cfgRdData[23] && cfgRdData[31:24] == 8'h00;
    endproperty
    property p_vendor;
        s_rd(8'h64) |=> cfgRdData == 32'h0034b009;
    endproperty
    property p_pm;
        s_rd(8'h44) |=> cfgRdData[23:0] == 24'h000000;
    endproperty
    property p_addr;
        s_rd(8'h50) |=> cfgRdData[1:0] == 2'h0 && msgAddress[1:0] == 2'h0;
    endproperty
    property p_pay;
        s_rd(8'h58) |=> cfgRdData[31:16] == 16'h0000;
    endproperty
    property p_tmr;
        s_rd(8'h70) |=> cfgRdData[31] && !cfgRdData[15];
    endproperty
    property p_legacy;
        legacyIntPermit != msgIntEnable;
    endproperty
    property p_en_cause;
        $changed(msgIntEnable) |-> $past(cfgWrEn || loadWrEn, 2);
    endproperty

    a_rd_pulse: assert property (p_rd_pulse) else $error("read valid timing wrong");
    a_no_stray: assert property (p_no_stray) else $error("read valid without read");
    a_ctl: assert property (p_ctl) else $error("message control constants wrong");
    a_vendor: assert property (p_vendor) else $error("vendor header wrong");
    a_pm: assert property (p_pm) else $error("bridge bits not zero");
    a_addr: assert property (p_addr) else $error("address low bits set");
    a_pay: assert property (p_pay) else $error("payload upper bits set");
    a_tmr: assert property (p_tmr) else $error("timer fixed bits wrong");
    a_legacy: assert property (p_legacy) else $error("legacy permit wrong");
    a_en_cause: assert property (p_en_cause) else $error("enable changed unwritten");
endmodule // swpc_cfg_checker

bind swpc_config_regs swpc_cfg_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys),
    .reset_n(reset_n), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .loadWrEn(loadWrEn),
    .msgIntEnable(msgIntEnable), .legacyIntPermit(legacyIntPermit), .msgAddress(msgAddress));

/* swpc_config_regs_test.sv */
/*
 * self-checking bench for the switch port capability register group.
 * assumes the design and its bound checker are compiled before it.
 */
`timescale 1ns/10ps

module swpc_config_regs_test;
    logic clk_sys = 0, reset_n = 0, cfgWrEn = 0, cfgRdEn = 0, loadWrEn = 0;
    logic [7:0] cfgAddr = 0, loadAddr = 0;
    logic [3:0] cfgByteEn = 0, loadByteEn = 0;
    logic [31:0] cfgWrData = 0, loadWrData = 0;
    logic [11:0] builtinReplay = 12'h123;
    logic [13:0] builtinAck = 14'h0456;
    wire [31:0] cfgRdData, testWord0, testWord1;
    wire cfgRdValid, msgIntEnable, legacyIntPermit, pmCapDisable, msgCapDisable;
    wire vgaDecodeEnable;
    wire [2:0] msgMultiEnable;
    wire [63:0] msgAddress;
    wire [15:0] msgPayload;
    wire [11:0] replayTimeout;
    wire [13:0] ackLatency;
    int fail_count = 0, total_checks = 0, cycles = 0;

    swpc_config_regs #(.ADDR_W(8)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .loadWrEn(loadWrEn), .loadAddr(loadAddr), .loadByteEn(loadByteEn),
        .loadWrData(loadWrData), .builtinReplay(builtinReplay), .builtinAck(builtinAck),
        .msgIntEnable(msgIntEnable), .legacyIntPermit(legacyIntPermit),
        .msgMultiEnable(msgMultiEnable), .msgAddress(msgAddress), .msgPayload(msgPayload),
        .replayTimeout(replayTimeout), .ackLatency(ackLatency), .pmCapDisable(pmCapDisable),
        .msgCapDisable(msgCapDisable), .vgaDecodeEnable(vgaDecodeEnable),
        .testWord0(testWord0), .testWord1(testWord1));

    // ----------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ----------------------------------------------------------------
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // cut a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // who[0] host, who[1] load port; load carries inverted data
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                      input logic [1:0] who);
        @(posedge clk_sys) #1;
        cfgWrEn = who[0];
        loadWrEn = who[1];
        cfgAddr = a;
        loadAddr = a;
        cfgByteEn = b;
        loadByteEn = b;
        cfgWrData = d;
        loadWrData = ~d;
        @(posedge clk_sys) #1;
        cfgWrEn = 0;
        loadWrEn = 0;
    endtask
    // read one dword and compare it
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys) #1;
        cfgRdEn = 1;
        cfgAddr = a;
        @(posedge clk_sys) #1;
        cfgRdEn = 0;
        check("rdValid", cfgRdValid, 1);
        check(n, cfgRdData, e);
    endtask
    // let control outputs follow the stored registers
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic rst;
        reset_n = 0;
        repeat (6) @(posedge clk_sys);
        #1 reset_n = 1;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults;
        check("legacy", legacyIntPermit, 1);
        check("vga", vgaDecodeEnable, 1);
        check("test0", testWord0, 32'h04001060);
        check("test1", testWord1, 32'h00000800);
        rdc("pm", 8'h44, 32'h00000000);
        rdc("ctl", 8'h4c, 32'h00846405);
        rdc("alo", 8'h50, 32'h00000000);
        rdc("ahi", 8'h54, 32'h00000000);
        rdc("pay", 8'h58, 32'h00000000);
        rdc("vend", 8'h64, 32'h0034b009);
        rdc("t0", 8'h68, 32'h04001060);
        rdc("t1", 8'h6c, 32'h00000800);
        rdc("tmr", 8'h70, 32'h80000000);
    endtask
    task automatic t_msg;
        wr(8'h4c, 4'hf, 32'hffffffff, 2'b01);
        wr(8'h50, 4'hf, 32'hffffffff, 2'b01);
        wr(8'h54, 4'hf, 32'hffffffff, 2'b01);
        wr(8'h58, 4'hf, 32'hffffffff, 2'b01);
        rdc("ctl", 8'h4c, 32'h00f56405);
        rdc("alo", 8'h50, 32'hfffffffc);
        rdc("ahi", 8'h54, 32'hffffffff);
        rdc("pay", 8'h58, 32'h0000ffff);
        check("msgEn", msgIntEnable, 1);
        check("legacy", legacyIntPermit, 0);
        check("mme", msgMultiEnable, 3'h7);
        check("addr", msgAddress, 64'hffffffff_fffffffc);
        check("payOut", msgPayload, 16'hffff);
        wr(8'h50, 4'h1, 32'h00000000, 2'b01);
        wr(8'h4c, 4'hf, 32'h00000000, 2'b01);
        settle;
        check("msgEn", msgIntEnable, 0);
        check("legacy", legacyIntPermit, 1);
        rdc("alo", 8'h50, 32'hffffff00);
    endtask
    task automatic t_refused;
        wr(8'h44, 4'hf, 32'hffffffff, 2'b01);
        wr(8'h64, 4'hf, 32'hffffffff, 2'b01);
        wr(8'h80, 4'hf, 32'hffffffff, 2'b01);
        rdc("pm", 8'h44, 32'h00000000);
        rdc("vend", 8'h64, 32'h0034b009);
        rdc("unmapped", 8'h80, 32'h00000000);
    endtask
    task automatic t_tests;
        wr(8'h68, 4'hf, 32'h12345678, 2'b01);
        wr(8'h6c, 4'hf, 32'ha5a5a5a5, 2'b01);
        settle;
        rdc("t0", 8'h68, 32'h12345678);
        rdc("t1", 8'h6c, 32'ha5a5a5a5);
        check("test0", testWord0, 32'h12345678);
        check("test1", testWord1, 32'ha5a5a5a5);
    endtask
    task automatic t_timers;
        check("replay", replayTimeout, 12'h123);
        check("ack", ackLatency, 14'h0456);
        wr(8'h70, 4'hf, 32'hffffffff, 2'b01);
        rdc("tmr", 8'h70, 32'hffff1fff);
        settle;
        check("replay", replayTimeout, 12'hfff);
        check("ack", ackLatency, 14'h3fff);
        check("pmDis", pmCapDisable, 0);
        check("msgDis", msgCapDisable, 0);
        builtinReplay = 12'h321;
        settle;
        check("replay", replayTimeout, 12'hfff);
        wr(8'h70, 4'hf, 32'h00000000, 2'b01);
        settle;
        check("replay", replayTimeout, 12'h321);
        check("ack", ackLatency, 14'h0456);
    endtask
    // load port: inverted data reaches loadable and host-writable bits
    task automatic t_load;
        wr(8'h44, 4'hf, 32'h00000000, 2'b10);
        wr(8'h70, 4'hf, 32'hffff9fff, 2'b10);
        wr(8'h58, 4'hf, 32'h0000a5a5, 2'b10);
        rdc("pm", 8'h44, 32'hff000000);
        rdc("tmr", 8'h70, 32'h80006000);
        rdc("pay", 8'h58, 32'h00005a5a);
        settle;
        check("pmDis", pmCapDisable, 1);
        check("msgDis", msgCapDisable, 1);
        wr(8'h68, 4'hf, 32'h11111111, 2'b11);
        rdc("t0", 8'h68, 32'heeeeeeee);
    endtask

    // main sequence, second reset mid-run, then the defaults are checked again
    initial begin
        rst;
        t_defaults;
        t_msg;
        t_refused;
        t_tests;
        t_timers;
        t_load;
        rst;
        t_defaults;
        wrap_up;
    end
endmodule // swpc_config_regs_test

/* swpc_map.vh */
/*
 * constants for the switch port capability register group:
 * offsets, writable and loadable masks, reset values, read-only fields.
 * assumes dword-aligned byte offsets on the configuration port.
 */
// Functional notes
// - message enable clear forbids messages; set forbids INTx
// - 64-bit address capable bit reads one
// - address bits 31:2 writable, 1:0 reserved
// - upper address writable, resets zero
// - message capability id 05h, next 64h
// - vendor capability id 09h, next B0h
// - vendor length field reads 0034h
// - user replay timeout 12 bits, resets zero
// - replay override selects user timeout value
// - user ack latency 14 bits, resets zero
// - ack override selects user latency value
// - graphics range decode enable reads one
// - loadable defaults replaced by SMBus or EEPROM
// - bridge power and B2/B3 bits read zero
// - power data byte read-only, resets 00h
// - test words reset 0400_1060h and 0000_0800h
`ifndef SWPC_MAP_VH
`define SWPC_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SWPC_OFF_PM_DATA 8'h44
`define SWPC_OFF_MSG_CTL 8'h4c
`define SWPC_OFF_ADDR_LO 8'h50
`define SWPC_OFF_ADDR_HI 8'h54
`define SWPC_OFF_PAYLOAD 8'h58
`define SWPC_OFF_VENDOR 8'h64
`define SWPC_OFF_TEST0 8'h68
`define SWPC_OFF_TEST1 8'h6c
`define SWPC_OFF_TIMERS 8'h70

// ----------------------------------------------------------------
// masks: host-writable and load-writable bits
// ----------------------------------------------------------------
`define SWPC_WM_PM_DATA 32'h00000000
`define SWPC_LM_PM_DATA 32'hff000000
`define SWPC_WM_MSG_CTL 32'h00710000
`define SWPC_WM_ADDR_LO 32'hfffffffc
`define SWPC_WM_FULL 32'hffffffff
`define SWPC_WM_PAYLOAD 32'h0000ffff
`define SWPC_WM_TIMERS 32'h7fff1fff
`define SWPC_LM_TIMERS 32'h7fff7fff

// ----------------------------------------------------------------
// reset values and constant read fields
// ----------------------------------------------------------------
`define SWPC_RST_ZERO 32'h00000000
`define SWPC_RST_TEST0 32'h04001060
`define SWPC_RST_TEST1 32'h00000800
`define SWPC_RO_MSG_CTL 32'h00846405
`define SWPC_RO_VENDOR 32'h0034b009
`define SWPC_RO_TIMERS 32'h80000000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SWPC_BIT_MSG_EN 16
`define SWPC_MME_HI 22
`define SWPC_MME_LO 20
`define SWPC_BIT_REPLAY_EN 12
`define SWPC_BIT_PM_DIS 13
`define SWPC_BIT_MSG_DIS 14
`define SWPC_ACK_HI 29
`define SWPC_ACK_LO 16
`define SWPC_BIT_ACK_EN 30
`define SWPC_BIT_VGA 31

`endif
